// >>> rtl/dss_pkg.sv
// shared constants and carrier types for the disc status and sense block
package dss_pkg;
  // bus command bytes, parity bit ignored (low seven bits compared)
  localparam logic [6:0] CMD_UNLISTEN  = 7'h3f;
  localparam logic [6:0] CMD_UNTALK    = 7'h5f;
  localparam logic [6:0] CMD_DEVCLR    = 7'h14;
  localparam logic [6:0] LISTEN_BASE   = 7'h20;
  localparam logic [6:0] TALK_BASE     = 7'h40;
  localparam logic [6:0] SEC_BASE      = 7'h60;
  localparam logic [6:0] SEC_TARGET    = 7'h68;
  localparam logic [6:0] SEC_TARGET_B  = 7'h6a;
  localparam logic [6:0] SEC_PHYS      = 7'h6c;
  // opcodes
  localparam logic [4:0] OPC_STATUS    = 5'h03;
  localparam logic [4:0] OPC_ADDR      = 5'h14;
  localparam logic [4:0] OPC_WEAR      = 5'h16;
  localparam logic [7:0] WEAR_CTRL     = 8'h01;
  localparam logic [7:0] EXTRA_BYTE    = 8'h01;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  // primary status codes
  localparam logic [4:0] PST_NONE      = 5'h00;
  localparam logic [4:0] PST_BADOPC    = 5'h01;
  localparam logic [4:0] PST_IOPROG    = 5'h0a;
  // completion codes
  localparam logic [1:0] CC_OK         = 2'h0;
  localparam logic [1:0] CC_ERR        = 2'h1;
  localparam logic [1:0] CC_POWERUP    = 2'h2;
  // media type and readiness encodings
  localparam logic [3:0] MT_EMPTY      = 4'h0;
  localparam logic [3:0] MT_BLANK      = 4'h5;
  localparam logic [3:0] MT_OWNFMT     = 4'h6;
  localparam logic [1:0] RDY_OK        = 2'h0;
  localparam logic [1:0] RDY_NONE      = 2'h3;
  // drive status word bit positions
  localparam int DSW_SUMERR = 15;
  localparam int DSW_TYPE   = 11;
  localparam int DSW_ATTN   = 7;
  localparam int DSW_WPROT  = 6;
  localparam int DSW_FAULT  = 5;
  localparam int DSW_FIRST  = 4;
  localparam int DSW_SEEKCK = 3;
  localparam int DSW_READY  = 0;
  // response lengths
  localparam logic [2:0] RESP_LEN      = 3'd4;
  localparam logic [2:0] RESP_LAST     = 3'd4;
  // apb register byte offsets
  localparam logic [7:0] REG_CONFIG    = 8'h00;
  localparam logic [7:0] REG_STATE     = 8'h04;
  localparam logic [7:0] REG_TARGET    = 8'h08;
  localparam logic [4:0] RST_BUSADDR   = 5'h00;

  typedef struct packed {
    logic        faultEv;     // drive hardware failure seen
    logic        seekDoneEv;  // seek finished, good or bad
    logic        seekFailEv;  // seek failed
    logic        present;     // disc inserted
    logic        connected;   // drive connected
    logic        fmtKnown;    // disc in own format
    logic        tabProtect;  // tab in protect position
    logic        wearOver;    // wear limit exceeded
    logic        speedBad;    // spindle speed bad at format
    logic [15:0] actCyl;      // actuator cylinder
    logic [7:0]  actHead;     // actuator head
    logic [31:0] wear;        // loaded-head revolutions
  } dss_drive_s;

  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
    logic       valid;
  } dss_talk_s;

  typedef struct packed {
    logic       haltHs;      // stop handshake pulse
    logic       chipReset;   // bus interface chip reset pulse
    logic       recal;       // recalibrate all drives pulse
    logic       headUnload;  // unload head pulse
    logic       motorOff;    // stop motor pulse
  } dss_clr_s;
endpackage

// >>> rtl/dss_disc_status_sense_clear.sv
// status, sense and device clear command interpreter with apb registers
// Operation
// - summary error bit set on fault, seek check or any not-ready.
// - media type field 0000 empty, 0101 blank/unknown, 0110 own format.
// - attention set at seek end, cleared after status read.
// - write protect on tab, wear exceeded or bad format speed.
// - drive fault set on hardware failure, cleared after status read.
// - first-status flag always reads zero.
// - seek check set on failed seek, cleared after status read.
// - readiness field 00 ready, 11 no disc or no drive.
// - good status read zeroes primary status, flags, completion code.
// - bad secondary, length or opcode gives program error, code 1.
// - short read re-enables parallel poll on untalk.
// - reads past four bytes get one extra byte with eoi, 1 except 0 for wear.
// - logical address reply: cylinder two bytes, head, sector.
// - unknown sense opcode records illegal opcode, code 1.
// - physical address reply: actuator cylinder, head, zero byte.
// - wear query returns four count bytes msb first, then dummy.
// - device clear halts handshake, disables poll, resets chip, code 0.
// - device clear recalibrates, zeroes target and unit, unloads, stops.
// - device clear removes power-up completion code 2.
//
// Design decisions made here: the register addresses and the APB register port.
module dss_disc_status_sense_clear
(
  input  wire logic              clk_sys,    // 20 MHz system clock
  input  wire logic              rstn,       // sync reset, active low
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction
  input  wire logic [7:0]        paddr,      // apb byte address
  input  wire logic [31:0]       pwdata,     // apb write data
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error
  input  wire logic [7:0]        busByte,    // byte from bus
  input  wire logic              busAtn,     // byte is a command
  input  wire logic              busStrobe,  // byte accepted, one cycle
  input  wire logic              talkTake,   // host took talk byte
  input  wire dss_pkg::dss_drive_s drv,      // drive state and events
  output dss_pkg::dss_talk_s     talk,       // byte offered to host
  output logic                   ppEnable,   // parallel poll response on
  output dss_pkg::dss_clr_s      clrOut,     // device clear pulses
  output logic [1:0]             unitSel     // selected unit
);
  import dss_pkg::*;

  typedef enum {ST_IDLE, ST_LISTEN, ST_TALK} dss_state_e;

  dss_state_e  state;
  logic [4:0]  busAddr;
  logic [4:0]  pstat;
  logic [1:0]  ccode;
  logic        attn;
  logic        fault;
  logic        seekCk;
  logic [15:0] tgtCyl;
  logic [7:0]  tgtHead;
  logic [7:0]  tgtSect;
  logic [6:0]  secReg;
  logic        secSeen;
  logic [2:0]  rxCount;
  logic [7:0]  rxByte [0:2];
  logic [7:0]  resp [0:4];
  logic [2:0]  txIdx;
  logic [2:0]  pend;
  logic        statusSent;

  localparam logic [2:0] PEND_NONE = 3'd0;
  localparam logic [2:0] PEND_STAT = 3'd1;
  localparam logic [2:0] PEND_LOG  = 3'd2;
  localparam logic [2:0] PEND_PHY  = 3'd3;
  localparam logic [2:0] PEND_WEAR = 3'd4;

  // drive status word, built live from drive inputs
  wire [3:0]  mediaType = !(drv.present && drv.connected) ? MT_EMPTY
                        : (drv.fmtKnown ? MT_OWNFMT : MT_BLANK);
  wire [1:0]  readyF = (drv.present && drv.connected) ? RDY_OK
                     : RDY_NONE;
  wire        wProt = drv.tabProtect | drv.wearOver | drv.speedBad;
  wire        sumErr = fault | seekCk | (readyF != RDY_OK);
  wire        firstF = 1'b0;
  wire [15:0] dsw = {sumErr, mediaType, 3'b000, attn, wProt, fault,
                     firstF, seekCk, 1'b0, readyF};

  // bus command decode
  wire [6:0] cmd7      = busByte[6:0];
  wire       atnStb    = busStrobe & busAtn;
  wire       dataStb   = busStrobe & ~busAtn;
  wire       myListen  = atnStb & (cmd7 == (LISTEN_BASE | {2'b00, busAddr}));
  wire       myTalk    = atnStb & (cmd7 == (TALK_BASE | {2'b00, busAddr}));
  wire       isUnl     = atnStb & (cmd7 == CMD_UNLISTEN);
  wire       isUnt     = atnStb & (cmd7 == CMD_UNTALK);
  wire       isDevClr  = atnStb & (cmd7 == CMD_DEVCLR);
  wire       isSec     = atnStb & (cmd7[6:5] == SEC_BASE[6:5]);
  wire       otherAddr = atnStb & ~isSec & ~isUnl & ~isUnt & ~isDevClr
                       & ~myListen & ~myTalk & (cmd7[6:5] != 2'b00);

  // command check when listening ends
  wire [4:0] opc      = rxByte[0][4:0];
  wire       secTgt   = (secReg == SEC_TARGET) | (secReg == SEC_TARGET_B);
  wire       secPhy   = secReg == SEC_PHYS;
  wire       secOk    = secTgt | secPhy;
  wire       opcKnown = (opc == OPC_STATUS) | (opc == OPC_ADDR)
                      | (opc == OPC_WEAR);
  wire       okStat   = secTgt & (opc == OPC_STATUS) & (rxCount == 3'd2);
  wire       okLog    = secTgt & (opc == OPC_ADDR) & (rxCount == 3'd1);
  wire       okPhy    = secPhy & (opc == OPC_ADDR) & (rxCount == 3'd1);
  wire       okWear   = secPhy & (opc == OPC_WEAR) & (rxCount == 3'd3)
                      & (rxByte[1] == WEAR_CTRL);
  wire       cmdGood  = okStat | okLog | okPhy | okWear;
  wire       evalNow  = (state == ST_LISTEN) & isUnl & secSeen
                      & (rxCount != 3'd0);
  wire       badOpc   = evalNow & secOk & ~opcKnown;
  wire       badProg  = evalNow & ~cmdGood & ~badOpc;
  wire [2:0] next_pend = okStat ? PEND_STAT : okLog ? PEND_LOG
                       : okPhy ? PEND_PHY : okWear ? PEND_WEAR
                       : PEND_NONE;

  // talk phase
  wire       talkStart = (state == ST_TALK) & isSec & (cmd7 == SEC_TARGET)
                       & (pend != PEND_NONE);
  wire       byteTaken = talk.valid & talkTake;
  wire       statDone  = byteTaken & (txIdx == RESP_LEN - 3'd1)
                       & statusSent;
  wire [7:0] unitByte  = {6'b000000, unitSel};

  // read-to-clear flags: a new event wins over the clearing read
  wire next_attn   = drv.seekDoneEv | (attn & ~statDone);
  wire next_fault  = drv.faultEv | (fault & ~statDone);
  wire next_seekCk = drv.seekFailEv | (seekCk & ~statDone);

  // apb decode; one wait state so read data comes from a flop
  wire apbAcc   = psel & penable & ~pready;
  wire hitCfg   = paddr == REG_CONFIG;
  wire hitState = paddr == REG_STATE;
  wire hitTgt   = paddr == REG_TARGET;
  wire hitAny   = hitCfg | hitState | hitTgt;
  wire apbWr    = apbAcc & pwrite & hitAny;
  wire [31:0] rdMux = hitCfg ? {27'h0, busAddr}
                    : hitState ? {pstat, 8'h00, ccode, ppEnable, dsw}
                    : hitTgt ? {tgtSect, tgtHead, tgtCyl}
                    : 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= apbAcc;
      pslverr <= apbAcc & ~hitAny;
      prdata  <= (apbAcc & ~pwrite) ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      busAddr <= RST_BUSADDR;
    else if (apbWr && hitCfg)
      busAddr <= pwdata[4:0];
  end

  // stored status persists until a good status read, a device clear or a good non-status command
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pstat  <= PST_NONE;
      ccode  <= CC_POWERUP;
      attn   <= 1'b0;
      fault  <= 1'b0;
      seekCk <= 1'b0;
    end
    else if (isDevClr)
    begin
      pstat  <= PST_NONE;
      ccode  <= CC_OK;
      attn   <= drv.seekDoneEv;
      fault  <= drv.faultEv;
      seekCk <= drv.seekFailEv;
    end
    else
    begin
      attn   <= next_attn;
      fault  <= next_fault;
      seekCk <= next_seekCk;
      if (badOpc)
      begin
        pstat <= PST_BADOPC;
        ccode <= CC_ERR;
      end
      else if (badProg)
      begin
        if (pstat == PST_NONE)
          pstat <= PST_IOPROG;
        ccode <= CC_ERR;
      end
      else if (evalNow && !okStat)
      begin
        pstat <= PST_NONE;
        ccode <= CC_OK;
      end
      else if (statDone)
      begin
        pstat <= PST_NONE;
        ccode <= CC_OK;
      end
    end
  end

  // target address set by software, unit by status and wear commands; device clear zeroes both
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || isDevClr)
    begin
      tgtCyl  <= 16'h0;
      tgtHead <= 8'h00;
      tgtSect <= 8'h00;
      unitSel <= 2'h0;
    end
    else if (apbWr && hitTgt)
    begin
      tgtCyl  <= pwdata[15:0];
      tgtHead <= pwdata[23:16];
      tgtSect <= pwdata[31:24];
    end
    else if (evalNow && okStat)
      unitSel <= rxByte[1][1:0];
    else if (evalNow && okWear)
      unitSel <= rxByte[2][1:0];
  end

  // clear pulses toward bus chip and drives
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      clrOut <= '0;
    else
    begin
      clrOut.haltHs     <= isDevClr;
      clrOut.chipReset  <= isDevClr;
      clrOut.recal      <= isDevClr;
      clrOut.headUnload <= isDevClr;
      clrOut.motorOff   <= isDevClr;
    end
  end

  // listen, talk and command capture
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || isDevClr)
    begin
      state   <= ST_IDLE;
      secReg  <= 7'h00;
      secSeen <= 1'b0;
      rxCount <= 3'd0;
      pend    <= PEND_NONE;
    end
    else
    begin
      if (myListen)
      begin
        state   <= ST_LISTEN;
        secSeen <= 1'b0;
        rxCount <= 3'd0;
      end
      else if (myTalk)
        state <= ST_TALK;
      else if (isUnl && state == ST_LISTEN)
        state <= ST_IDLE;
      else if (isUnt && state == ST_TALK)
        state <= ST_IDLE;
      else if (otherAddr)
        state <= ST_IDLE;
      if (isSec && state == ST_LISTEN)
      begin
        secReg  <= cmd7;
        secSeen <= 1'b1;
        rxCount <= 3'd0;
      end
      if (dataStb && state == ST_LISTEN && rxCount != 3'd7)
      begin
        if (rxCount < 3'd3)
          rxByte[rxCount[1:0]] <= busByte;
        rxCount <= rxCount + 3'd1;
      end
      if (evalNow)
        pend <= next_pend;
      else if (talkStart)
        pend <= PEND_NONE;
    end
  end

  // response snapshot taken when the talk secondary arrives
  always_ff @(posedge clk_sys)
  begin
    if (talkStart)
    begin
      case (pend)
        PEND_STAT:
        begin
          resp[0] <= {3'b000, pstat};
          resp[1] <= unitByte;
          resp[2] <= dsw[15:8];
          resp[3] <= dsw[7:0];
          resp[4] <= EXTRA_BYTE;
        end
        PEND_LOG:
        begin
          resp[0] <= tgtCyl[15:8];
          resp[1] <= tgtCyl[7:0];
          resp[2] <= tgtHead;
          resp[3] <= tgtSect;
          resp[4] <= EXTRA_BYTE;
        end
        PEND_PHY:
        begin
          resp[0] <= drv.actCyl[15:8];
          resp[1] <= drv.actCyl[7:0];
          resp[2] <= drv.actHead;
          resp[3] <= ZERO_BYTE;
          resp[4] <= EXTRA_BYTE;
        end
        PEND_WEAR:
        begin
          resp[0] <= drv.wear[31:24];
          resp[1] <= drv.wear[23:16];
          resp[2] <= drv.wear[15:8];
          resp[3] <= drv.wear[7:0];
          resp[4] <= ZERO_BYTE;
        end
        default:
          resp <= '{ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, ZERO_BYTE, EXTRA_BYTE};
      endcase
    end
  end

  // byte sequencer; fifth byte carries eoi and ends the reply
  wire [7:0] nextData = resp[txIdx + 3'd1];
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || isDevClr)
    begin
      talk       <= '0;
      txIdx      <= 3'd0;
      statusSent <= 1'b0;
    end
    else if (talkStart)
    begin
      talk.valid <= 1'b0;
      txIdx      <= 3'd7;
      statusSent <= pend == PEND_STAT;
    end
    else if (txIdx == 3'd7)
    begin
      talk.data  <= resp[0];
      talk.eoi   <= 1'b0;
      talk.valid <= 1'b1;
      txIdx      <= 3'd0;
    end
    else if (isUnt || (atnStb && state == ST_TALK))
    begin
      talk.valid <= 1'b0;
      talk.eoi   <= 1'b0;
    end
    else if (byteTaken)
    begin
      if (txIdx == RESP_LAST)
        talk.valid <= 1'b0;
      else
      begin
        talk.data <= nextData;
        talk.eoi  <= (txIdx + 3'd1) == RESP_LAST;
        txIdx     <= txIdx + 3'd1;
      end
    end
  end

  // poll response off while addressed, back on at untalk, or at unlisten when pend held no reply before that unlisten, even if the command it ends sets one
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || isDevClr)
      ppEnable <= 1'b0;
    else if (myListen || myTalk)
      ppEnable <= 1'b0;
    else if (isUnt && state == ST_TALK)
      ppEnable <= 1'b1;
    else if (isUnl && state == ST_LISTEN && pend == PEND_NONE)
      ppEnable <= 1'b1;
  end

endmodule // dss_disc_status_sense_clear

// >>> test/dss_host_model.sv
// host bus controller model: sends bus bytes and takes talk bytes
module dss_host_model
  import dss_pkg::*;
(
  input  wire logic          clk_sys,   // system clock
  input  wire dss_pkg::dss_talk_s talk, // byte offered by the device
  output logic [7:0]         busByte,   // byte on the bus
  output logic               busAtn,    // byte is a command
  output logic               busStrobe, // byte handshake pulse
  output logic               talkTake   // talk byte taken pulse
);
  initial
  begin
    busByte = 8'h00;
    busAtn = 1'b0;
    busStrobe = 1'b0;
    talkTake = 1'b0;
  end

  task automatic send(input logic atn, input logic [7:0] b);
    @(posedge clk_sys);
    busByte <= b;
    busAtn <= atn;
    busStrobe <= 1'b1;
    @(posedge clk_sys);
    busStrobe <= 1'b0;
    busByte <= ~b; // released lines do not keep the last byte
  endtask

  // unknown data comes back when nothing is offered in time
  task automatic take(output logic [7:0] d, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (talk.valid !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk_sys);
    end
    d = (talk.valid === 1'b1) ? talk.data : 8'hxx;
    e = talk.eoi;
    talkTake <= 1'b1;
    @(posedge clk_sys);
    talkTake <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule // dss_host_model

// >>> test/dss_disc_chk.sv
// concurrent checks on the status, sense and clear block ports
module dss_disc_chk
  import dss_pkg::*;
(
  input wire logic        clk_sys,  // clock
  input wire logic        rstn,     // reset
  input wire logic        psel,     // apb
  input wire logic        penable,  // apb
  input wire logic        pwrite,   // apb
  input wire logic [7:0]  paddr,    // apb
  input wire logic [31:0] pwdata,   // apb
  input wire logic [31:0] prdata,   // apb
  input wire logic        pready,   // apb
  input wire logic        pslverr,  // apb
  input wire logic [7:0]  busByte,  // bus byte
  input wire logic        busAtn,   // command flag
  input wire logic        busStrobe, // byte strobe
  input wire logic        talkTake, // talk taken
  input wire dss_pkg::dss_drive_s drv, // drive
  input wire dss_pkg::dss_talk_s  talk, // talk byte
  input wire logic        ppEnable, // poll enable
  input wire dss_pkg::dss_clr_s   clrOut, // clear pulses
  input wire logic [1:0]  unitSel   // unit
);
  wire logic driveUp = drv.present && drv.connected;
  wire logic protect = drv.tabProtect | drv.wearOver | drv.speedBad;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // drive word is only trusted while no error code stands
  sequence s_rdState;
    pready && psel && !pwrite && paddr == REG_STATE
      && prdata[18:17] != CC_ERR;
  endsequence
  sequence s_cmd(logic [6:0] c);
    busStrobe && busAtn && busByte[6:0] == c;
  endsequence

  a_sum_err:
  assert property (s_rdState |-> prdata[15] ==
    (prdata[5] | prdata[3] | (prdata[1:0] != RDY_OK)))
  else $error("summary error bit wrong");
  a_media_type:
  assert property (s_rdState |-> prdata[14:11] == (!driveUp ? MT_EMPTY :
    (drv.fmtKnown ? MT_OWNFMT : MT_BLANK)))
  else $error("media type field wrong");
  a_ready_field:
  assert property (s_rdState |-> prdata[1:0] ==
    (driveUp ? RDY_OK : RDY_NONE))
  else $error("readiness field wrong");
  a_first_zero:
  assert property (s_rdState |-> !prdata[4])
  else $error("first status bit set");
  a_write_prot:
  assert property (s_rdState |-> prdata[6] == protect)
  else $error("write protect bit wrong");
  a_dev_clear:
  assert property (s_cmd(CMD_DEVCLR) |=> &clrOut && !ppEnable
    && unitSel == 2'h0)
  else $error("device clear actions missing");
  a_clr_pulse:
  assert property (clrOut.recal |=> !clrOut.recal)
  else $error("recalibrate pulse too long");
  a_poll_untalk:
  assert property (s_cmd(CMD_UNTALK) |-> ##[1:3] ppEnable)
  else $error("poll not enabled after untalk");
  a_extra_byte:
  assert property (talk.valid && talk.eoi |->
    talk.data == EXTRA_BYTE || talk.data == ZERO_BYTE)
  else $error("last reply byte wrong");
  a_apb_answer:
  assert property (psel && penable && !pready |=> pready ##1 !pready)
  else $error("apb answer not one cycle");
endmodule // dss_disc_chk

bind dss_disc_status_sense_clear dss_disc_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busByte(busByte),
  .busAtn(busAtn), .busStrobe(busStrobe), .talkTake(talkTake),
  .drv(drv), .talk(talk), .ppEnable(ppEnable), .clrOut(clrOut),
  .unitSel(unitSel));

// >>> test/tb_top.sv
// testbench for the status, sense and clear block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dss_pkg::*;
  localparam logic [4:0] BA = 5'h05;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic        busAtn, busStrobe, talkTake, ppEnable, err;
  logic [7:0]  paddr, busByte;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  unitSel;
  dss_drive_s  drv;
  dss_talk_s   talk;
  dss_clr_s    clrOut;
  int          fails, cmpCount;

  dss_disc_status_sense_clear uut (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busByte(busByte), .busAtn(busAtn),
    .busStrobe(busStrobe), .talkTake(talkTake), .drv(drv),
    .talk(talk), .ppEnable(ppEnable), .clrOut(clrOut),
    .unitSel(unitSel));
  dss_host_model host (.clk_sys(clk_sys), .talk(talk),
    .busByte(busByte), .busAtn(busAtn), .busStrobe(busStrobe),
    .talkTake(talkTake));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    if (fails == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmpCount++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic state(input logic [4:0] ps, input logic [1:0] cc,
                       input logic [15:0] dsw);
    apb(1'b0, REG_STATE, 32'h0);
    chk("state", {ps, 8'h00, cc, 17'h0}, {rd[31:17], 17'h0});
    if (cc !== CC_ERR) chk("drive word", 32'(dsw), 32'(rd[15:0]));
  endtask

  task automatic cmd(input logic [6:0] sec, input logic [31:0] b,
                     input int n);
    host.send(1'b1, {1'b0, LISTEN_BASE | 7'(BA)});
    host.send(1'b1, {1'b0, sec});
    for (int i = 0; i < n; i++)
      host.send(1'b0, b[31-8*i -: 8]);
    host.send(1'b1, {1'b0, CMD_UNLISTEN});
  endtask

  task automatic rsp(input logic [39:0] exp, input int n);
    logic [7:0] d;
    logic       e;
    host.send(1'b1, {1'b0, TALK_BASE | 7'(BA)});
    host.send(1'b1, {1'b0, SEC_TARGET});
    for (int i = 0; i < n; i++)
    begin
      host.take(d, e);
      chk("reply byte", 32'(exp[39-8*i -: 8]), 32'(d));
      chk("reply eoi", 32'(i == 4), 32'(e));
    end
    host.send(1'b1, {1'b0, CMD_UNTALK});
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test;
  end

  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    drv = '0;
    fails = 0;
    cmpCount = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    state(PST_NONE, CC_POWERUP, 16'h8003);
    apb(1'b1, REG_CONFIG, 32'(BA));
    apb(1'b0, REG_CONFIG, 32'h0);
    chk("config", 32'(BA), rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    {drv.present, drv.connected, drv.fmtKnown} <= 3'b111;
    apb(1'b1, REG_TARGET, 32'h07010123);
    host.send(1'b1, {1'b0, CMD_DEVCLR});
    state(PST_NONE, CC_OK, 16'h3000);
    apb(1'b0, REG_TARGET, 32'h0);
    chk("target", 32'h0, rd);
    chk("unit", 32'h0, 32'(unitSel));
    {drv.faultEv, drv.seekDoneEv, drv.seekFailEv} <= 3'b111;
    @(posedge clk_sys);
    {drv.faultEv, drv.seekDoneEv, drv.seekFailEv} <= 3'b000;
    repeat (4) @(posedge clk_sys);
    state(PST_NONE, CC_OK, 16'hb0a8);
    cmd(SEC_TARGET, {3'b0, OPC_STATUS, 24'h0}, 2);
    rsp({32'h0000b0a8, EXTRA_BYTE}, 5);
    state(PST_NONE, CC_OK, 16'h3000);
    apb(1'b1, REG_TARGET, 32'h07010123);
    cmd(SEC_TARGET_B, {3'b0, OPC_ADDR, 24'h0}, 1);
    rsp(40'h0123010701, 5);
    drv.actCyl <= 16'h0456;
    drv.actHead <= 8'h02;
    cmd(SEC_PHYS, {3'b0, OPC_ADDR, 24'h0}, 1);
    rsp(40'h0456020000, 4);
    repeat (3) @(posedge clk_sys);
    chk("poll enable", 32'h1, 32'(ppEnable));
    drv.wear <= 32'h89abcdef;
    cmd(SEC_PHYS, {3'b0, OPC_WEAR, WEAR_CTRL, 16'h0}, 3);
    rsp({32'h89abcdef, ZERO_BYTE}, 5);
    cmd(SEC_TARGET, {3'b0, OPC_STATUS, 24'h0}, 1);
    state(PST_IOPROG, CC_ERR, 16'h0);
    cmd(SEC_TARGET, {3'b0, OPC_STATUS, 8'h01, 16'h0}, 2);
    rsp({8'(PST_IOPROG), 24'h013000, EXTRA_BYTE}, 5);
    state(PST_NONE, CC_OK, 16'h3000);
    cmd(SEC_TARGET, 32'h1f000000, 1);
    state(PST_BADOPC, CC_ERR, 16'h0);
    host.send(1'b1, {1'b0, CMD_DEVCLR});
    for (int i = 0; i < 3; i++)
    begin
      {drv.tabProtect, drv.wearOver, drv.speedBad} <= 3'b001 << i;
      state(PST_NONE, CC_OK, 16'h3040);
    end
    {drv.tabProtect, drv.wearOver, drv.speedBad, drv.fmtKnown} <= '0;
    state(PST_NONE, CC_OK, 16'h2800);
    chk("unit", 32'h0, 32'(unitSel));
    cmd(7'h61, {3'b0, OPC_STATUS, 24'h0}, 2);
    state(PST_IOPROG, CC_ERR, 16'h0);
    stop_test;
  end
endmodule // tb_top
